// ---- ifr_pkg.sv ----
// Purpose: constants and types for the interrupt flag and enable bank
// Assumes: 16-bit registers, one aligned 32-bit Avalon word each
// Notes: masks mark implemented bits, all others read zero
// Functional notes
// - A flag reads one after its source requested or software wrote a one to it, zero otherwise.
// - An enable bit at one permits its request; at zero blocks it.
// - Unimplemented bits read zero and ignore writes.
// - All flags and enables reset to zero.
// - Software reads and writes every implemented flag and enable bit.
// - Flags one bits 15..8: serial B tx/rx, pin two, timers, compares, DMA two.
// - Flags one bits 7..0: captures, converter B, pin one, change, bit 2 unused, two-wire A.
// - Flags two bits 15..8: timer six, DMA four, bit 13 unused, compares, capture six.
// - Flags two bits 7..0: captures, DMA three, CAN A, SPI B event/error.
// - Flags three: only bits 13 and 8..0 implemented.
// - Flags four: only bits 7..4, 2 and 1 implemented.
// - Enables zero bits 15..8: bit 15 unused, DMA one down to timer three.
// - Enables zero bits 7..0: timer two down to external pin zero.
// - Flags zero bits 2..0: compare one, capture one, external pin zero.
package ifr_pkg;
  localparam int unsigned ifr_num_flag = 5;
  localparam int unsigned ifr_addr_width = 8;
  localparam logic [7:0] ifr_off_flags_zero = 8'h00;
  localparam logic [7:0] ifr_off_flags_one = 8'h04;
  localparam logic [7:0] ifr_off_flags_two = 8'h08;
  localparam logic [7:0] ifr_off_flags_three = 8'h0c;
  localparam logic [7:0] ifr_off_flags_four = 8'h10;
  localparam logic [7:0] ifr_off_enables_zero = 8'h14;
  localparam logic [4:0][7:0] ifr_flag_off = {ifr_off_flags_four, ifr_off_flags_three,
    ifr_off_flags_two, ifr_off_flags_one, ifr_off_flags_zero};
  localparam logic [15:0] ifr_mask_flags_zero = 16'h7fff;
  localparam logic [15:0] ifr_mask_flags_one = 16'hfffb;
  localparam logic [15:0] ifr_mask_flags_two = 16'hdfff;
  localparam logic [15:0] ifr_mask_flags_three = 16'h21ff;
  localparam logic [15:0] ifr_mask_flags_four = 16'h00f6;
  localparam logic [15:0] ifr_mask_enables_zero = 16'h7fff;
  localparam logic [4:0][15:0] ifr_flag_mask = {ifr_mask_flags_four, ifr_mask_flags_three,
    ifr_mask_flags_two, ifr_mask_flags_one, ifr_mask_flags_zero};
  localparam logic [15:0] ifr_reset_value = 16'h0000;
  localparam logic [31:0] ifr_read_unmapped = 32'h0000_0000;
  typedef struct packed {
    logic [15:0] four;
    logic [15:0] three;
    logic [15:0] two;
    logic [15:0] one;
    logic [15:0] zero;
  } ifr_word5_type;
  typedef enum logic {
    ifr_idle = 1'b0,
    ifr_ack = 1'b1
  } ifr_bus_state_type;
endpackage

// ---- ifr_bank.sv ----
// Purpose: interrupt flag registers zero to four and enable register zero
// Assumes: event inputs are one-cycle pulses from logic on the same clock
// Notes: every access takes one wait state, then completes
`timescale 1ns/100ps
`default_nettype none
module ifr_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripheral events, one bit per flag position
  input wire ifr_pkg::ifr_word5_type src_event,
  // Flag state and requests toward the core
  output ifr_pkg::ifr_word5_type flags,
  output logic [15:0] enables_zero,
  output logic [15:0] req_zero,
  output logic req_any
);
  ifr_pkg::ifr_bus_state_type bus_state;
  ifr_pkg::ifr_bus_state_type next_bus_state;
  logic [31:0] next_readdata;
  logic [15:0] flag_q [ifr_pkg::ifr_num_flag];
  logic [15:0] next_flag [ifr_pkg::ifr_num_flag];
  logic [15:0] set_seen [ifr_pkg::ifr_num_flag];
  logic [4:0][15:0] ev_vec;
  logic [15:0] enable_q;
  logic [15:0] next_enable;
  logic [15:0] lane_mask;
  logic wr_take;
  logic rd_start;
  logic addr_hit;

  assign ev_vec = src_event;
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_take = (bus_state == ifr_pkg::ifr_ack) && avs_write;
  assign rd_start = (bus_state == ifr_pkg::ifr_idle) && avs_read;
  // Any of the six register offsets; everything else reads zero
  assign addr_hit = avs_address inside {ifr_pkg::ifr_off_flags_zero,
    ifr_pkg::ifr_off_flags_one, ifr_pkg::ifr_off_flags_two, ifr_pkg::ifr_off_flags_three,
    ifr_pkg::ifr_off_flags_four, ifr_pkg::ifr_off_enables_zero};
  // One wait state gives the read mux a full cycle into a register
  assign avs_waitrequest = (avs_read || avs_write) && (bus_state == ifr_pkg::ifr_idle);

  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      ifr_pkg::ifr_idle: begin
        if (avs_read || avs_write) begin
          next_bus_state = ifr_pkg::ifr_ack;
        end
      end
      ifr_pkg::ifr_ack: begin
        next_bus_state = ifr_pkg::ifr_idle;
      end
      default: begin
        next_bus_state = ifr_pkg::ifr_idle;
      end
    endcase
  end

  always_comb begin
    next_readdata = avs_readdata;
    if (rd_start) begin
      next_readdata = ifr_pkg::ifr_read_unmapped;
      case (avs_address)
        ifr_pkg::ifr_off_flags_zero: next_readdata = {16'h0000, flag_q[0]};
        ifr_pkg::ifr_off_flags_one: next_readdata = {16'h0000, flag_q[1]};
        ifr_pkg::ifr_off_flags_two: next_readdata = {16'h0000, flag_q[2]};
        ifr_pkg::ifr_off_flags_three: next_readdata = {16'h0000, flag_q[3]};
        ifr_pkg::ifr_off_flags_four: next_readdata = {16'h0000, flag_q[4]};
        ifr_pkg::ifr_off_enables_zero: next_readdata = {16'h0000, enable_q};
        default: next_readdata = ifr_pkg::ifr_read_unmapped;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= ifr_pkg::ifr_idle;
      avs_readdata <= ifr_pkg::ifr_read_unmapped;
    end else begin
      bus_state <= next_bus_state;
      avs_readdata <= next_readdata;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ifr_pkg::ifr_num_flag; gi++) begin : g_flag
      // Events never look at the enable bit
      assign set_seen[gi] = ev_vec[gi] & ifr_pkg::ifr_flag_mask[gi];

      always_comb begin
        next_flag[gi] = flag_q[gi];
        if (wr_take && (avs_address == ifr_pkg::ifr_flag_off[gi])) begin
          // Byte lanes allow one half to be cleared alone
          next_flag[gi] = (flag_q[gi] & ~lane_mask) | (avs_writedata[15:0] & lane_mask);
        end
        // Set wins over a clearing write in the same cycle
        next_flag[gi] = next_flag[gi] | set_seen[gi];
        // Bit layouts
        next_flag[gi] = next_flag[gi] & ifr_pkg::ifr_flag_mask[gi];
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          flag_q[gi] <= ifr_pkg::ifr_reset_value;
        end else begin
          flag_q[gi] <= next_flag[gi];
        end
      end

      AST_FLAG_SET: assert property (@(posedge clock) disable iff (!rst_n)
        (set_seen[gi] != 16'h0000) |=> ((flag_q[gi] & $past(set_seen[gi])) ==
        $past(set_seen[gi])))
        else $error("event did not set its flag");

      AST_UNIMPL_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        (flag_q[gi] & ~ifr_pkg::ifr_flag_mask[gi]) == 16'h0000)
        else $error("unimplemented flag bit set");

      AST_NO_SPONT: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(wr_take) |-> ((flag_q[gi] & ~$past(flag_q[gi]) & ~$past(set_seen[gi]))
        == 16'h0000))
        else $error("flag rose without event or write");

      // A flag stays set until software writes it low
      AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !(wr_take && (avs_address == ifr_pkg::ifr_flag_off[gi])) |=>
        ((flag_q[gi] & $past(flag_q[gi])) == $past(flag_q[gi])))
        else $error("flag dropped without a write");

      // Event and clearing write in one cycle: the event survives
      AST_SET_WINS: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_take && (avs_address == ifr_pkg::ifr_flag_off[gi]) && (set_seen[gi] != 16'h0000))
        |=> ((flag_q[gi] & $past(set_seen[gi])) == $past(set_seen[gi])))
        else $error("clearing write beat an event");

      AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_take && (avs_address == ifr_pkg::ifr_flag_off[gi]) &&
        (avs_byteenable[1:0] == 2'h3) && (avs_writedata[15:0] == 16'h0000) &&
        (set_seen[gi] == 16'h0000)) |=> (flag_q[gi] == 16'h0000))
        else $error("zero write did not clear the flags");

      AST_WR_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_take && (avs_address == ifr_pkg::ifr_flag_off[gi]) &&
        (avs_byteenable[1:0] == 2'h3)) |=>
        (flag_q[gi] == (($past(avs_writedata[15:0]) | $past(set_seen[gi])) &
        ifr_pkg::ifr_flag_mask[gi])))
        else $error("flag register write not stored");

      // Only the low lane is written; the high byte keeps its bits
      AST_FLAG_LANE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_take && (avs_address == ifr_pkg::ifr_flag_off[gi]) &&
        (avs_byteenable[1:0] == 2'h1)) |=>
        (flag_q[gi][15:8] == (($past(flag_q[gi][15:8]) | $past(set_seen[gi][15:8])) &
        ifr_pkg::ifr_flag_mask[gi][15:8])))
        else $error("flag high byte changed on a low-lane write");

      AST_RD_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
        (avs_read && !avs_waitrequest && (avs_address == ifr_pkg::ifr_flag_off[gi]))
        |-> (avs_readdata == {16'h0000, $past(flag_q[gi])}))
        else $error("flag readback wrong");

      AST_RESET_FLAG: assert property (@(posedge clock)
        (rst_n && !$past(rst_n)) |-> (flag_q[gi] == 16'h0000))
        else $error("flag not zero after reset");
    end
  endgenerate

  always_comb begin
    next_enable = enable_q;
    if (wr_take && (avs_address == ifr_pkg::ifr_off_enables_zero)) begin
      next_enable = (enable_q & ~lane_mask) | (avs_writedata[15:0] & lane_mask);
    end
    next_enable = next_enable & ifr_pkg::ifr_mask_enables_zero;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= ifr_pkg::ifr_reset_value;
    end else begin
      enable_q <= next_enable;
    end
  end

  assign flags.zero = flag_q[0];
  assign flags.one = flag_q[1];
  assign flags.two = flag_q[2];
  assign flags.three = flag_q[3];
  assign flags.four = flag_q[4];
  assign enables_zero = enable_q;
  // Only enable register zero lives here; other enables sit downstream
  assign req_zero = flag_q[0] & enable_q;
  assign req_any = |req_zero;

  AST_RESET_ZERO: assert property (@(posedge clock)
    (rst_n && !$past(rst_n)) |-> ((enable_q == 16'h0000) && (req_any == 1'b0)))
    else $error("enables not zero after reset");

  AST_RESET_READ: assert property (@(posedge clock)
    (rst_n && !$past(rst_n)) |-> (avs_readdata == ifr_pkg::ifr_read_unmapped))
    else $error("read data not zero after reset");

  // Request path toward the core
  AST_REQ_GATE: assert property (@(posedge clock) disable iff (!rst_n)
    (enable_q == 16'h0000) [*2] |-> !req_any)
    else $error("request passed with all enables clear");

  AST_REQ_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
    ((set_seen[0] & enable_q) != 16'h0000) && !wr_take |=> req_any)
    else $error("enabled event raised no request");

  AST_REQ_NEEDS_EN: assert property (@(posedge clock) disable iff (!rst_n)
    (req_zero & ~enable_q) == 16'h0000)
    else $error("request passed a clear enable bit");

  AST_REQ_NEEDS_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    (req_zero & ~flag_q[0]) == 16'h0000)
    else $error("request without a pending flag");

  AST_REQ_BOTH: assert property (@(posedge clock) disable iff (!rst_n)
    ((flag_q[0] & enable_q) != 16'h0000) |-> req_any)
    else $error("enabled pending flag raised no request");

  AST_REQ_ANY: assert property (@(posedge clock) disable iff (!rst_n)
    req_any |-> (req_zero != 16'h0000))
    else $error("summary request without a source");

  // Request shows in the same cycle as the flag it comes from
  AST_REQ_SAME_CYCLE: assert property (@(posedge clock) disable iff (!rst_n)
    (((set_seen[0] & enable_q) != 16'h0000) &&
    !(wr_take && (avs_address == ifr_pkg::ifr_off_enables_zero))) |=>
    ((req_zero & $past(set_seen[0] & enable_q)) == $past(set_seen[0] & enable_q)))
    else $error("enabled event not requested with its flag");

  // Enable register, and the flags one write check
  AST_EN_MASK: assert property (@(posedge clock) disable iff (!rst_n)
    (enable_q & ~ifr_pkg::ifr_mask_enables_zero) == 16'h0000)
    else $error("unimplemented enable bit set");

  AST_EN_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !(wr_take && (avs_address == ifr_pkg::ifr_off_enables_zero)) |=> $stable(enable_q))
    else $error("enable changed without a write");

  AST_EN_WR: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_take && (avs_address == ifr_pkg::ifr_off_enables_zero) &&
    (avs_byteenable[1:0] == 2'h3)) |=>
    (enable_q == ($past(avs_writedata[15:0]) & ifr_pkg::ifr_mask_enables_zero)))
    else $error("enable write not stored");

  AST_EN_LANE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_take && (avs_address == ifr_pkg::ifr_off_enables_zero) &&
    (avs_byteenable[1:0] == 2'h1)) |=>
    (enable_q[15:8] == $past(enable_q[15:8])))
    else $error("enable high byte changed on a low-lane write");

  AST_EN_LANE_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_take && (avs_address == ifr_pkg::ifr_off_enables_zero) &&
    (avs_byteenable[1:0] == 2'h2)) |=>
    (enable_q[7:0] == $past(enable_q[7:0])))
    else $error("enable low byte changed on a high-lane write");

  AST_WR_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_take && (avs_address == ifr_pkg::ifr_off_flags_one) && (avs_byteenable[1:0] == 2'h3))
    |=> (flag_q[1] == (($past(avs_writedata[15:0]) | $past(set_seen[1])) &
    ifr_pkg::ifr_mask_flags_one)))
    else $error("flag write not stored");

  // Bus handshake and read path
  AST_WAIT_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");

  AST_WAIT_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    ((avs_read || avs_write) && (bus_state == ifr_pkg::ifr_idle)) |-> avs_waitrequest)
    else $error("first request cycle not stalled");

  AST_IDLE_NO_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without a request");

  AST_ACK_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    (bus_state == ifr_pkg::ifr_ack) |=> (bus_state == ifr_pkg::ifr_idle))
    else $error("bus stayed in the answer state");

  AST_RD_ENABLE: assert property (@(posedge clock) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && (avs_address == ifr_pkg::ifr_off_enables_zero))
    |-> (avs_readdata == {16'h0000, $past(enable_q)}))
    else $error("enable readback wrong");

  // Read data must hold until the next read starts
  AST_RD_STANDS: assert property (@(posedge clock) disable iff (!rst_n)
    !rd_start |=> $stable(avs_readdata))
    else $error("read data moved without a read");

  AST_RD_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && !addr_hit) |-> (avs_readdata == ifr_pkg::ifr_read_unmapped))
    else $error("unmapped read not zero");

  AST_RD_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
endmodule
`default_nettype wire

// ---- ifr_src_model.sv ----
// Purpose: peripheral event sources that set the bank's flags
// Assumes: bench raises fire for one cycle per event burst
// Notes: registered, so an event lands one edge after fire
`timescale 1ns/100ps
`default_nettype none
module ifr_src_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Command from the bench
  input wire ifr_pkg::ifr_word5_type fire,
  // One-cycle set pulses toward the bank
  output ifr_pkg::ifr_word5_type src_event
);
  // Idle sources drive zero so no stray set reaches the flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_event <= '0;
    end else begin
      src_event <= fire;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for the flag and enable bank
// Assumes: Avalon slave answers after its own wait state
// Notes: mask holds implemented bits, index 5 is enables zero
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ifr_pkg::ifr_word5_type fire = '0;
  ifr_pkg::ifr_word5_type src_event;
  ifr_pkg::ifr_word5_type flags;
  logic [15:0] enables_zero;
  logic [15:0] req_zero;
  logic req_any;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  logic [5:0][15:0] mask = {16'h7fff, 16'h00f6, 16'h21ff, 16'hdfff, 16'hfffb, 16'h7fff};
  logic [31:0] q;

  always #2 clock = ~clock;

  ifr_bank ifr_bank_i (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_event(src_event), .flags(flags),
    .enables_zero(enables_zero), .req_zero(req_zero), .req_any(req_any));
  ifr_src_model ifr_src_model_i (.clock(clock), .rst_n(rst_n), .fire(fire),
    .src_event(src_event));

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= {2'b00, be};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(i * 4), 16'h0000, 2'b11);
      chk(q, 80'h0);
    end
    chk(flags, 80'h0);
    chk({enables_zero, req_any}, 17'h0);
  endtask

  task automatic t_rw();
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'(i * 4), 16'hffff, 2'b11);
      bus(1'b0, 8'(i * 4), 16'h0000, 2'b11);
      chk(q, mask[i]);
      bus(1'b1, 8'(i * 4), 16'h0000, 2'b11);
      bus(1'b0, 8'(i * 4), 16'h0000, 2'b11);
      chk(q, 80'h0);
    end
  endtask

  task automatic t_unmapped();
    bus(1'b1, 8'h18, 16'hffff, 2'b11);
    bus(1'b0, 8'h18, 16'h0000, 2'b11);
    chk(q, 80'h0);
    chk(flags, 80'h0);
    chk(enables_zero, 16'h0);
  endtask

  task automatic t_events();
    @(posedge clock);
    fire <= '1;
    @(posedge clock);
    fire <= '0;
    repeat (2) @(posedge clock);
    chk(flags, mask[4:0]);
    chk({req_zero, req_any}, 80'h0);
    bus(1'b1, 8'h14, 16'h0007, 2'b11);
    @(posedge clock);
    chk({req_zero, req_any}, {16'h0007, 1'b1});
    bus(1'b1, 8'h00, 16'h7ffd, 2'b11);
    @(posedge clock);
    chk(req_zero, 16'h0005);
    bus(1'b1, 8'h14, 16'hffff, 2'b10);
    bus(1'b0, 8'h14, 16'h0000, 2'b11);
    chk(q, 16'h7f07);
  endtask

  // Lane writes, then an event landing on the edge of a clearing write
  task automatic t_set_wins();
    bus(1'b1, 8'h00, 16'h0000, 2'b01);
    bus(1'b0, 8'h00, 16'h0000, 2'b11);
    chk(q, 16'h7f00);
    fork
      bus(1'b1, 8'h00, 16'h0000, 2'b11);
      begin
        @(posedge clock);
        fire.zero[1] <= 1'b1;
        @(posedge clock);
        fire <= '0;
      end
    join
    @(posedge clock);
    chk({flags.zero, req_zero}, {16'h0002, 16'h0002});
    bus(1'b1, 8'h14, 16'h0000, 2'b01);
    bus(1'b0, 8'h14, 16'h0000, 2'b11);
    chk(q, 16'h7f00);
  endtask

  task automatic t_midreset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(flags, 80'h0);
    chk({enables_zero, req_zero, req_any}, 33'h0);
    bus(1'b0, 8'h14, 16'h0000, 2'b11);
    chk(q, 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_rw();
    t_unmapped();
    t_events();
    t_set_wins();
    t_midreset();
    wrap_up();
  end
endmodule
`default_nettype wire
